// ---- stall_pkg.sv ----
// Constants shared by the stall detector and its sample delay timer.
// Assumes one 100 MHz clock and an 8-bit back-EMF sample with a 62.5 mV step.
package stall_pkg;

  // Clock, register port, sample, average and delay timer geometry.
  localparam int unsigned CLK_FREQ_MHZ = 100;
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned BEMF_W       = 8;
  localparam int unsigned AVG_FRAC     = 3;
  localparam int unsigned AVG_W        = BEMF_W + AVG_FRAC;
  localparam int unsigned DLY_W        = 16;

  // Register offsets.
  localparam logic [ADDR_W-1:0] REG_CFG      = 8'h00;
  localparam logic [ADDR_W-1:0] REG_FLAGS    = 8'h04;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_BEMF     = 8'h10;

  // Configuration field positions.
  localparam int unsigned CFG_DELAY_LSB = 0;
  localparam int unsigned CFG_BLANK_LSB = 4;
  localparam int unsigned CFG_ABS_LSB   = 8;
  localparam int unsigned CFG_DEL_LSB   = 12;
  localparam int unsigned CFG_DC100_BIT = 16;
  localparam int unsigned CFG_JIT_BIT   = 17;
  localparam int unsigned CFG_RATE_BIT  = 18;
  localparam int unsigned CFG_STOP_BIT  = 19;
  localparam int unsigned CFG_W         = 20;
  localparam logic [CFG_W-1:0] CFG_RESET = 20'h0_0000;

  // Flag and interrupt bit positions.
  localparam int unsigned FLG_DROP  = 0;
  localparam int unsigned FLG_RISE  = 1;
  localparam int unsigned FLG_FLOOR = 2;
  localparam int unsigned FLG_STALL = 3;
  localparam int unsigned FLG_LOST  = 4;
  localparam int unsigned IRQ_STALL = 0;
  localparam int unsigned IRQ_LOST  = 1;
  localparam int unsigned IRQ_REFUS = 2;
  localparam int unsigned IRQ_W     = 3;

  // Threshold scaling: 0.25 V is 4 steps, 0.5 V is 8 steps of 62.5 mV.
  localparam int unsigned DEL_SHIFT = 2;
  localparam int unsigned ABS_SHIFT = 3;
  localparam logic [3:0]  THR_OFF   = 4'h0;

  // Sample delays in microseconds for each PWM rate.
  localparam int unsigned DELAY_US_RATE0 [0:7] = '{87, 130, 174, 217, 261, 304, 348, 391};
  localparam int unsigned DELAY_US_RATE1 [0:7] = '{43, 65, 87, 109, 130, 152, 174, 196};

endpackage : stall_pkg

// ---- step_delay_timer.sv ----
// Down-counter that waits a loaded number of cycles and then pulses done.
// Assumes start is a one-cycle pulse; a new start restarts the wait.
`timescale 1ns/10ps
`default_nettype none
module step_delay_timer (
  input  wire logic                     core_clk,
  input  wire logic                     rst_b,
  input  wire logic                     start,
  input  wire logic [stall_pkg::DLY_W-1:0] load,
  output logic                          busy,
  output logic                          done
);
  import stall_pkg::*;

  logic [DLY_W-1:0] cnt_q;
  logic [DLY_W-1:0] cnt_d;
  logic             done_d;
  logic [DLY_W-1:0] one_w;

  assign one_w  = {{(DLY_W-1){1'b0}}, 1'b1};
  assign busy   = (cnt_q != '0);
  assign done_d = !start && (cnt_q == one_w); // [RQ6]
  assign cnt_d  = start ? ((load == '0) ? one_w : load) : (busy ? cnt_q - one_w : cnt_q);

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cnt_q <= '0;
      done  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      done  <= done_d;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  chk_timer_start: assert property (start |=> busy) // [RQ6]
    else $error("Delay timer did not start.");
  chk_timer_end: assert property (busy && !start && cnt_q == one_w |=> done && !busy) // [RQ6]
    else $error("Delay timer did not finish on the last count.");

endmodule : step_delay_timer
`default_nettype wire

// ---- sensorless_stall_detect.sv ----
// Sensorless stall detector: delayed back-EMF sampling, running average,
// delta and absolute thresholds, blanking, full-duty masking and flags.
// Assumes full_step is a one-cycle pulse per full step, all inputs are
// synchronous to core_clk, and back_emf_voltage is valid whenever it is read.
// Function
// RQ1: Combined stall is OR of three flags.
// RQ2: Drop flag when sample below average minus delta.
// RQ3: Rise flag when sample above average plus delta.
// RQ4: Floor flag when sample below absolute level.
// RQ5: Stall stopping the motor sets lost step.
// RQ6: Sample delay field picks one of eight delays.
// RQ7: Host picks largest delay below one full step.
// RQ8: Blank evaluation N full steps after acceleration.
// RQ9: Absolute code zero disables, else 0.5 V steps.
// RQ10: Delta code zero disables, else 0.25 V steps.
// RQ11: Mask evaluation at full duty when enabled.
// RQ12: Host enables full-duty mask near full duty.
// RQ13: Host keeps PWM jitter off during detection.
// RQ14: PWM rate bit selects the delay column.
// RQ15: Refuse goto while fault or lost step set.
// RQ16: Stall flags hold until status is read.
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module sensorless_stall_detect #(
  parameter int unsigned CYCLES_PER_US = stall_pkg::CLK_FREQ_MHZ
) (
  input  wire logic                         core_clk,
  input  wire logic                         rst_b,
  input  wire logic [stall_pkg::ADDR_W-1:0] addr,
  input  wire logic [stall_pkg::DATA_W-1:0] wr_data,
  input  wire logic                         wr_en,
  input  wire logic                         rd_en,
  output logic      [stall_pkg::DATA_W-1:0] rd_data_q,
  input  wire logic [stall_pkg::BEMF_W-1:0] back_emf_voltage,
  input  wire logic                         full_step,
  input  wire logic                         accel_active,
  input  wire logic                         pwm_full_duty,
  input  wire logic                         goto_target_cmd,
  input  wire logic                         thermal_shutdown,
  input  wire logic                         undervoltage,
  input  wire logic                         elec_defect,
  output logic                              goto_accept_q,
  output logic                              motor_stop_q,
  output logic                              stall_q,
  output logic                              bemf_drop_flag,
  output logic                              bemf_rise_flag,
  output logic                              bemf_floor_flag,
  output logic                              lost_step_flag,
  output logic                              pwm_jitter_en,
  output logic                              pwm_rate_sel,
  output logic                              irq_q
);
  import stall_pkg::*;

  logic [CFG_W-1:0]  cfg_q;
  logic [IRQ_W-1:0]  irq_stat_q;
  logic [IRQ_W-1:0]  irq_stat_d;
  logic [IRQ_W-1:0]  irq_mask_q;
  logic [2:0]        blank_cnt_q;
  logic [2:0]        blank_cnt_d;
  logic [AVG_W-1:0]  avg_q;
  logic [AVG_W-1:0]  avg_d;
  logic              avg_valid_q;
  logic [BEMF_W-1:0] last_sample_q;
  logic              drop_d;
  logic              rise_d;
  logic              floor_d;
  logic              lost_d;

  // Configuration fields.
  wire [2:0] sample_delay_sel       = cfg_q[CFG_DELAY_LSB +: 3];
  wire [2:0] post_accel_blank_steps = cfg_q[CFG_BLANK_LSB +: 3];
  wire [3:0] abs_bemf_threshold     = cfg_q[CFG_ABS_LSB +: 4];
  wire [3:0] delta_bemf_threshold   = cfg_q[CFG_DEL_LSB +: 4];
  wire       full_duty_mask_en      = cfg_q[CFG_DC100_BIT];
  wire       stop_on_stall_en       = cfg_q[CFG_STOP_BIT];

  // Register decode.
  wire cfg_wr   = wr_en && (addr == REG_CFG);
  wire stat_wr  = wr_en && (addr == REG_IRQ_STAT);
  wire mask_wr  = wr_en && (addr == REG_IRQ_MASK);
  wire flags_rd = rd_en && (addr == REG_FLAGS);

  // Sample delay lookup; the rate bit chooses the column.
  wire [DLY_W-1:0] delay_cyc_w = pwm_rate_sel // [RQ14]
    ? DLY_W'(DELAY_US_RATE1[sample_delay_sel] * CYCLES_PER_US) // [RQ6]
    : DLY_W'(DELAY_US_RATE0[sample_delay_sel] * CYCLES_PER_US); // [RQ6]

  // Evaluation is only allowed outside acceleration, blanking and masked full duty.
  wire duty_masked = full_duty_mask_en && pwm_full_duty; // [RQ11]
  wire eval_ok     = !accel_active && (blank_cnt_q == 3'h0) && !duty_masked; // [RQ8] [RQ11]
  wire eval_start  = full_step && eval_ok;
  wire timer_done;
  wire timer_busy;
  wire eval_now    = timer_done && eval_ok;

  step_delay_timer u_delay (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .start    (eval_start),
    .load     (delay_cyc_w),
    .busy     (timer_busy),
    .done     (timer_done)
  );

  // Thresholds in sample steps of 62.5 mV.
  wire [BEMF_W+1:0] del_lvl = (BEMF_W+2)'(delta_bemf_threshold) << DEL_SHIFT; // [RQ10]
  wire [BEMF_W+1:0] abs_lvl = (BEMF_W+2)'(abs_bemf_threshold) << ABS_SHIFT;   // [RQ9]
  wire [BEMF_W+1:0] smp_w   = (BEMF_W+2)'(back_emf_voltage);
  wire [BEMF_W+1:0] back_emf_average = (BEMF_W+2)'(avg_q[AVG_W-1:AVG_FRAC]);

  wire del_on    = (delta_bemf_threshold != THR_OFF) && avg_valid_q; // [RQ10]
  wire abs_on    = (abs_bemf_threshold != THR_OFF);                  // [RQ9]
  wire drop_set  = eval_now && del_on && (smp_w + del_lvl < back_emf_average); // [RQ2]
  wire rise_set  = eval_now && del_on && (smp_w > back_emf_average + del_lvl); // [RQ3]
  wire floor_set = eval_now && abs_on && (smp_w < abs_lvl);                   // [RQ4]
  wire any_set   = drop_set || rise_set || floor_set;
  wire stop_now  = any_set && stop_on_stall_en;

  // Flags hold until the flag register is read; a new event beats the clear.
  assign drop_d  = drop_set  || (bemf_drop_flag  && !flags_rd); // [RQ16]
  assign rise_d  = rise_set  || (bemf_rise_flag  && !flags_rd); // [RQ16]
  assign floor_d = floor_set || (bemf_floor_flag && !flags_rd); // [RQ16]
  assign lost_d  = stop_now  || (lost_step_flag  && !flags_rd); // [RQ5]

  // Exponential running average with weight one eighth.
  assign avg_d = avg_valid_q
    ? AVG_W'(avg_q - (avg_q >> AVG_FRAC) + AVG_W'(back_emf_voltage))
    : AVG_W'({back_emf_voltage, {AVG_FRAC{1'b0}}});

  // Blanking reloads while accelerating and counts down on full steps after.
  assign blank_cnt_d = accel_active ? post_accel_blank_steps // [RQ8]
                     : (full_step && blank_cnt_q != 3'h0) ? blank_cnt_q - 3'h1 : blank_cnt_q;

  wire goto_blocked = lost_step_flag || thermal_shutdown || undervoltage || elec_defect; // [RQ15]

  wire [IRQ_W-1:0] irq_events = {goto_target_cmd && goto_blocked, stop_now, any_set};
  assign irq_stat_d = irq_events | (irq_stat_q & ~(stat_wr ? wr_data[IRQ_W-1:0] : '0));

  // Read mux; unmapped offsets read as zero.
  wire [DATA_W-1:0] flags_w = DATA_W'({lost_step_flag, stall_q, bemf_floor_flag,
                                       bemf_rise_flag, bemf_drop_flag});
  wire [DATA_W-1:0] rd_mux =
      (addr == REG_CFG)      ? DATA_W'(cfg_q)      :
      (addr == REG_FLAGS)    ? flags_w             :
      (addr == REG_IRQ_STAT) ? DATA_W'(irq_stat_q) :
      (addr == REG_IRQ_MASK) ? DATA_W'(irq_mask_q) :
      (addr == REG_BEMF)     ? DATA_W'({back_emf_average[BEMF_W-1:0], last_sample_q}) :
                               32'h0000_0000;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cfg_q      <= CFG_RESET;
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      rd_data_q  <= 32'h0000_0000;
      irq_q      <= 1'b0;
    end else begin
      if (cfg_wr)
        cfg_q <= wr_data[CFG_W-1:0];
      if (mask_wr)
        irq_mask_q <= wr_data[IRQ_W-1:0];
      irq_stat_q <= irq_stat_d;
      irq_q      <= |(irq_stat_d & (mask_wr ? wr_data[IRQ_W-1:0] : irq_mask_q));
      rd_data_q  <= rd_en ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pwm_jitter_en <= 1'b0;
      pwm_rate_sel  <= 1'b0;
    end else if (cfg_wr) begin
      pwm_jitter_en <= wr_data[CFG_JIT_BIT];
      pwm_rate_sel  <= wr_data[CFG_RATE_BIT]; // [RQ14]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      blank_cnt_q   <= 3'h0;
      avg_q         <= '0;
      avg_valid_q   <= 1'b0;
      last_sample_q <= '0;
    end else begin
      blank_cnt_q <= blank_cnt_d;
      if (eval_now) begin
        avg_q         <= avg_d;
        avg_valid_q   <= 1'b1;
        last_sample_q <= back_emf_voltage;
      end
    end
  end

  // The combined flag is taken from the same next values as the three flags.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      bemf_drop_flag  <= 1'b0;
      bemf_rise_flag  <= 1'b0;
      bemf_floor_flag <= 1'b0;
      lost_step_flag  <= 1'b0;
      stall_q         <= 1'b0;
      motor_stop_q    <= 1'b0;
      goto_accept_q   <= 1'b0;
    end else begin
      bemf_drop_flag  <= drop_d;
      bemf_rise_flag  <= rise_d;
      bemf_floor_flag <= floor_d;
      lost_step_flag  <= lost_d;                          // [RQ5]
      stall_q         <= drop_d || rise_d || floor_d;     // [RQ1]
      motor_stop_q    <= stop_now;                        // [RQ5]
      goto_accept_q   <= goto_target_cmd && !goto_blocked; // [RQ15]
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence flags_read_s;
    rd_en && (addr == REG_FLAGS);
  endsequence

  sequence step_while_blank_s;
    full_step && (blank_cnt_q != 3'h0);
  endsequence

  sequence stall_stop_s;
    any_set && stop_on_stall_en;
  endsequence

  sequence goto_clear_s;
    goto_target_cmd && !goto_blocked;
  endsequence

  chk_stall_or_flags: assert property (stall_q == (bemf_drop_flag || bemf_rise_flag || bemf_floor_flag)) // [RQ1]
    else $error("Combined stall differs from the OR of the flags.");
  chk_drop_detect: assert property (drop_set |=> bemf_drop_flag && stall_q) // [RQ2]
    else $error("Drop event did not raise its flag.");
  chk_rise_detect: assert property (rise_set |=> bemf_rise_flag && stall_q) // [RQ3]
    else $error("Rise event did not raise its flag.");
  chk_floor_detect: assert property (eval_now && abs_on && smp_w < abs_lvl |=> bemf_floor_flag) // [RQ4]
    else $error("Floor event did not raise its flag.");
  chk_stop_lost_step: assert property (motor_stop_q |-> lost_step_flag && stall_q) // [RQ5]
    else $error("Stop on stall without lost step.");
  chk_blank_no_eval: assert property (step_while_blank_s |-> !eval_start) // [RQ8]
    else $error("Evaluation started during blanking.");
  chk_blank_reload: assert property ($fell(accel_active) |-> blank_cnt_q == $past(post_accel_blank_steps)) // [RQ8]
    else $error("Blanking count not loaded after acceleration.");
  chk_floor_disabled: assert property (abs_bemf_threshold == THR_OFF |-> !floor_set) // [RQ9]
    else $error("Absolute detection active while disabled.");
  chk_delta_disabled: assert property (delta_bemf_threshold == THR_OFF |=> $stable(bemf_drop_flag) || !bemf_drop_flag) // [RQ10]
    else $error("Delta detection active while disabled.");
  chk_full_duty_mask: assert property (full_duty_mask_en && pwm_full_duty |-> !eval_now && !eval_start) // [RQ11]
    else $error("Evaluation at full duty while masked.");
  chk_goto_refuse: assert property (goto_target_cmd && goto_blocked |=> !goto_accept_q && irq_stat_q[IRQ_REFUS]) // [RQ15]
    else $error("Goto accepted while blocked.");
  chk_flag_hold: assert property (bemf_drop_flag && !flags_rd |=> bemf_drop_flag) // [RQ16]
    else $error("Drop flag lost before a status read.");
  chk_read_clear: assert property (flags_read_s ##0 !any_set |=> !bemf_drop_flag && !bemf_rise_flag && !bemf_floor_flag) // [RQ16]
    else $error("Flags not cleared by a status read.");
  chk_lost_hold: assert property (lost_step_flag && !flags_rd |=> lost_step_flag) // [RQ16]
    else $error("Lost step flag lost before a status read.");
  chk_stop_pulse: assert property (stall_stop_s |=> motor_stop_q && lost_step_flag) // [RQ5]
    else $error("Stall with stop enabled did not stop the motor.");
  chk_stop_needs_en: assert property (!stop_on_stall_en |=> !motor_stop_q) // [RQ5]
    else $error("Motor stopped with stop on stall disabled.");
  chk_goto_accept: assert property (goto_clear_s |=> goto_accept_q) // [RQ15]
    else $error("Goto refused while no fault was set.");
  chk_accept_cause: assert property (goto_accept_q |-> $past(goto_target_cmd)) // [RQ15]
    else $error("Goto accepted without a request.");
  chk_refuse_sticky: assert property (irq_stat_q[IRQ_REFUS] && !stat_wr |=> irq_stat_q[IRQ_REFUS]) // [RQ15]
    else $error("Refused goto status lost without a clear.");
  // Acceleration reloads the count, so only quiet full steps may decrement it.
  chk_blank_count: assert property (step_while_blank_s ##0 !accel_active // [RQ8]
    |=> blank_cnt_q == $past(blank_cnt_q) - 3'h1)
    else $error("Blanking count did not step down on a full step.");
  chk_delta_quiet: assert property (delta_bemf_threshold == THR_OFF |-> !drop_set && !rise_set) // [RQ10]
    else $error("Delta compare fired while disabled.");
  chk_timer_idle: assert property (timer_done |-> !timer_busy) // [RQ6]
    else $error("Delay timer still counting when it finished.");
  chk_irq_level: assert property (irq_q == |(irq_stat_q & irq_mask_q))
    else $error("Interrupt line differs from masked status.");
  chk_read_idle: assert property (!rd_en |=> rd_data_q == '0)
    else $error("Read data not zero outside a read.");

endmodule : sensorless_stall_detect
`default_nettype wire

// ---- motor_emf_model.sv ----
// Stand-in for the stepper coils and ramp: presents a back-EMF level and
// turns a step request into a one-cycle full step pulse.
// Assumes step_go is a one-cycle pulse synchronous to core_clk.
`timescale 1ns/10ps
`default_nettype none
module motor_emf_model (
  input  wire logic                         core_clk,
  input  wire logic                         rst_b,
  input  wire logic                         step_go,
  input  wire logic [stall_pkg::BEMF_W-1:0] emf_level,
  output logic                              full_step,
  output logic      [stall_pkg::BEMF_W-1:0] back_emf_voltage
);
  import stall_pkg::*;
  // The level moves only on an edge, as a sampled coil voltage would.
  always_ff @(posedge core_clk) begin
    full_step        <= rst_b & step_go;
    back_emf_voltage <= emf_level;
  end
endmodule : motor_emf_model
`default_nettype wire

// ---- sensorless_stall_detect_tb.sv ----
// Self-checking bench for the stall detector: register map, delay timing
// for every code, thresholds, blanking, full-duty masking and goto refusal.
// Assumes the design runs with one cycle per microsecond to keep delays short.
`timescale 1ns/10ps
`default_nettype none
module sensorless_stall_detect_tb;
  import stall_pkg::*;
  localparam int CYC = 1;
  logic              core_clk = 1'b0, rst_b = 1'b0, wr_en = 1'b0, rd_en = 1'b0, step_go = 1'b0;
  logic              accel_active = 1'b0, pwm_full_duty = 1'b0, goto_target_cmd = 1'b0;
  logic              thermal_shutdown = 1'b0, undervoltage = 1'b0, elec_defect = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wr_data = '0, rd_data_q, rv;
  logic [BEMF_W-1:0] emf_level = '0, back_emf_voltage;
  logic              full_step, goto_accept_q, motor_stop_q, stall_q, bemf_drop_flag;
  logic              bemf_rise_flag, bemf_floor_flag, lost_step_flag, pwm_jitter_en;
  logic              pwm_rate_sel, irq_q;
  int                n_mismatch = 0, n_compared = 0, dly = 0;

  always #5 core_clk = ~core_clk;

  motor_emf_model coil (.core_clk(core_clk), .rst_b(rst_b), .step_go(step_go),
    .emf_level(emf_level), .full_step(full_step), .back_emf_voltage(back_emf_voltage));

  sensorless_stall_detect #(.CYCLES_PER_US(CYC)) uut (.core_clk(core_clk), .rst_b(rst_b),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q),
    .back_emf_voltage(back_emf_voltage), .full_step(full_step), .accel_active(accel_active),
    .pwm_full_duty(pwm_full_duty), .goto_target_cmd(goto_target_cmd),
    .thermal_shutdown(thermal_shutdown), .undervoltage(undervoltage),
    .elec_defect(elec_defect), .goto_accept_q(goto_accept_q), .motor_stop_q(motor_stop_q),
    .stall_q(stall_q), .bemf_drop_flag(bemf_drop_flag), .bemf_rise_flag(bemf_rise_flag),
    .bemf_floor_flag(bemf_floor_flag), .lost_step_flag(lost_step_flag),
    .pwm_jitter_en(pwm_jitter_en), .pwm_rate_sel(pwm_rate_sel), .irq_q(irq_q));

  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  task automatic chk_word(input logic [DATA_W-1:0] got, exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, exp, input string what);
    chk_word({31'h0, got}, {31'h0, exp}, what);
  endtask : chk_bit

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge core_clk);
    wr_en   <= 1'b0;
    @(posedge core_clk);
  endtask : wr

  // The flag pins are compared before the read that clears them.
  task automatic chk_flags(input logic [DATA_W-1:0] exp, input string what);
    chk_word(DATA_W'({lost_step_flag, stall_q, bemf_floor_flag, bemf_rise_flag,
                      bemf_drop_flag}), exp, what);
    rd(REG_FLAGS);
    chk_word(rv, exp, what);
  endtask : chk_flags

  task automatic rd(input logic [ADDR_W-1:0] a);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 rv = rd_data_q;
    @(posedge core_clk);
  endtask : rd

  // The expected delay comes from the rate bit and the code, in cycles.
  task automatic cfg(input logic [DATA_W-1:0] c);
    wr(REG_CFG, c);
    dly = CYC * (c[CFG_RATE_BIT] ? DELAY_US_RATE1[c[2:0]] : DELAY_US_RATE0[c[2:0]]);
  endtask : cfg

  function automatic logic [DATA_W-1:0] mk(input logic [2:0] sel, blank,
    input logic [3:0] ab, dl, input logic dc, rate, stop);
    return {12'h000, stop, rate, 1'b0, dc, dl, ab, 1'b0, blank, 1'b0, sel};
  endfunction : mk

  // A stall seen early or late by one cycle fails the pre or post check.
  task automatic run_step(input logic [7:0] v, input logic exp, stop, pre);
    emf_level <= v;
    step_go   <= 1'b1;
    @(posedge core_clk);
    step_go   <= 1'b0;
    repeat (1 + dly) @(posedge core_clk);
    #1 if (pre) chk_bit(stall_q, 1'b0, "stall before delay");
    @(posedge core_clk);
    #1 chk_bit(stall_q, exp, "stall after delay");
    chk_bit(motor_stop_q, stop, "motor stop pulse");
    @(posedge core_clk);
  endtask : run_step

  task automatic go(input logic exp);
    goto_target_cmd <= 1'b1;
    @(posedge core_clk);
    goto_target_cmd <= 1'b0;
    #1 chk_bit(goto_accept_q, exp, "goto accept");
    @(posedge core_clk);
  endtask : go

  initial begin
    repeat (100_000) @(posedge core_clk);
    n_mismatch++;
    summarize();
  end

  initial begin
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    chk_bit(stall_q | irq_q | lost_step_flag | goto_accept_q | pwm_rate_sel, 1'b0, "reset");
    for (int i = 0; i < 6; i++) begin
      rd(ADDR_W'(i * 4));
      chk_word(rv, 32'h0000_0000, "reset value");
    end
    wr(8'h14, 32'hFFFF_FFFF);
    rd(8'h14);
    chk_word(rv, 32'h0000_0000, "unmapped");
    wr(REG_CFG, 32'hFFFF_FFFF);
    rd(REG_CFG);
    chk_word(rv, 32'h000F_FFFF, "cfg unused bits");
    chk_bit(pwm_jitter_en, 1'b1, "jitter mirror");
    $display("test reset and map done");
    wr(REG_IRQ_MASK, 32'h0000_0007);
    cfg(mk(3'h0, 3'h0, 4'h0, 4'h1, 1'b0, 1'b1, 1'b1));
    rd(REG_CFG);
    chk_word(rv, 32'h000C_1000, "cfg readback");
    chk_bit(pwm_rate_sel, 1'b1, "rate mirror");
    chk_bit(pwm_jitter_en, 1'b0, "jitter off");
    run_step(8'h64, 1'b0, 1'b0, 1'b1);
    rd(REG_BEMF);
    chk_word(rv, 32'h0000_6464, "seeded average");
    run_step(8'h50, 1'b1, 1'b1, 1'b1);
    go(1'b0);
    rd(REG_IRQ_STAT);
    chk_word(rv, 32'h0000_0007, "irq status");
    chk_bit(irq_q, 1'b1, "irq raised");
    chk_flags(32'h0000_0019, "drop flags");
    chk_flags(32'h0000_0000, "flags cleared");
    go(1'b1);
    for (int k = 0; k < 3; k++) begin
      {elec_defect, undervoltage, thermal_shutdown} <= 3'(1 << k);
      @(posedge core_clk);
      go(1'b0);
    end
    {elec_defect, undervoltage, thermal_shutdown} <= 3'h0;
    @(posedge core_clk);
    go(1'b1);
    wr(REG_IRQ_STAT, 32'h0000_0007);
    rd(REG_IRQ_STAT);
    chk_word(rv, 32'h0000_0000, "irq cleared");
    chk_bit(irq_q, 1'b0, "irq low");
    wr(REG_IRQ_MASK, 32'h0000_0000);
    run_step(8'h96, 1'b1, 1'b1, 1'b1);
    chk_bit(irq_q, 1'b0, "irq masked");
    wr(REG_IRQ_MASK, 32'h0000_0003);
    chk_flags(32'h0000_001A, "rise flags");
    chk_bit(irq_q, 1'b1, "irq unmasked");
    wr(REG_IRQ_STAT, 32'h0000_0003);
    rd(REG_IRQ_STAT);
    chk_word(rv, 32'h0000_0000, "irq w1c");
    $display("test delta and goto done");
    for (int i = 0; i < 16; i++) begin
      cfg(mk(i[2:0], 3'h0, 4'(i % 15 + 1), 4'h0, 1'b0, i[3], 1'b0));
      run_step(8'((i % 15 + 1) * 8 - 1), 1'b1, 1'b0, 1'b1);
      chk_flags(32'h0000_000C, "floor flags");
    end
    run_step(8'h08, 1'b0, 1'b0, 1'b1);
    cfg(mk(3'h0, 3'h0, 4'h0, 4'h0, 1'b0, 1'b1, 1'b0));
    run_step(8'h00, 1'b0, 1'b0, 1'b1);
    $display("test delay table and floor done");
    cfg(mk(3'h0, 3'h2, 4'h9, 4'h0, 1'b0, 1'b1, 1'b0));
    accel_active <= 1'b1;
    @(posedge core_clk);
    accel_active <= 1'b0;
    @(posedge core_clk);
    run_step(8'h3C, 1'b0, 1'b0, 1'b1);
    run_step(8'h3C, 1'b0, 1'b0, 1'b1);
    run_step(8'h3C, 1'b1, 1'b0, 1'b1);
    chk_flags(32'h0000_000C, "after blanking");
    cfg(mk(3'h0, 3'h0, 4'h9, 4'h0, 1'b1, 1'b1, 1'b0));
    pwm_full_duty <= 1'b1;
    run_step(8'h3C, 1'b0, 1'b0, 1'b1);
    cfg(mk(3'h0, 3'h0, 4'h9, 4'h0, 1'b0, 1'b1, 1'b0));
    run_step(8'h3C, 1'b1, 1'b0, 1'b1);
    pwm_full_duty <= 1'b0;
    chk_flags(32'h0000_000C, "full duty flags");
    $display("test blanking and masking done");
    summarize();
  end
endmodule : sensorless_stall_detect_tb
`default_nettype wire
